// File: design/fmop_pkg.sv
// Shared constants and types of the fault mask and over-supply protection block
package fmop_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CH_MODE_ADDR = 8'h01;
    localparam logic [7:0] OPEN_WIRE_ENABLE_ADDR = 8'h02;
    localparam logic [7:0] SUPPLY_SHORT_DETECT_ENABLE_ADDR = 8'h03;
    localparam logic [7:0] OPEN_WIRE_CHANNEL_FLAGS_ADDR = 8'h04;
    localparam logic [7:0] OVERLOAD_CHANNEL_FLAGS_ADDR = 8'h05;
    localparam logic [7:0] FAULT_PIN_MASK_ADDR = 8'h0f;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int OVER_SUPPLY_MASK_BIT = 3;
    localparam int OPEN_WIRE_OFF_MASK_BIT = 2;
    localparam int CURRENT_LIMIT_MASK_BIT = 1;
    localparam int THERMAL_OVERLOAD_MASK_BIT = 0;
    localparam int PROTECT_ENABLE_BIT = 4;
    localparam logic [7:0] FAULT_PIN_MASK_RESET = 8'hbe;
    localparam logic [3:0] CH_MODE_RESET = 4'h0;
    localparam logic [7:0] OPEN_WIRE_ENABLE_RESET = 8'h00;
    localparam logic [4:0] SUPPLY_SHORT_DETECT_RESET = 5'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 40000;
    localparam int DEBOUNCE_TIME_US = 200;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * CLK_FREQ_KHZ) / 1000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fmop_reg_req_type;

    typedef struct packed {
        logic over_supply_summary_bit;
        logic open_wire_summary_bit;
        logic overcurrent_summary_bit;
        logic thermal_summary_bit;
    } fmop_summary_type;

endpackage

// File: design/fmop_top.sv
// Fault pin masking, fault flags and over-supply protection for four channels
`timescale 1ns/10ps
// Overview of operation
// - Mask bit 0 passes source, 1 blocks
// - Mask bit 3 gates over-supply; flagged when enabled
// - Mask bit 2 gates open-wire-off error
// - Enabled open wire sets channel and summary flag
// - Mask bit 1 gates current-limit error
// - Current limit always flagged per channel, summary
// - Mask bit 0 gates thermal overload error
// - Thermal overload always flagged per channel, summary
// - Reset leaves every channel high-side output
// - Output on when data, enable, sync high
// - Over-supply flag only after 200us debounce
// - Flag plus protect enable kills gate, switch
// - Over-supply latched until host clears it
// - Input mode holds gate driver off
// - Gate enable bit turns gate driver on
// - Gate enable 0: flag set, no action
module fmop_top #(
    parameter int NUM_CH = 4,
    parameter int DEBOUNCE_CYCLES = fmop_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input fmop_pkg::fmop_reg_req_type reg_req,
    output logic [7:0] reg_rdata_r,
    // Pin control
    input wire logic [NUM_CH-1:0] channel_line,
    input wire logic output_enable_in,
    input wire logic output_sync_input,
    // Raw detector levels
    input wire logic [NUM_CH-1:0] over_supply_raw,
    input wire logic [NUM_CH-1:0] open_wire_raw,
    input wire logic [NUM_CH-1:0] current_limit_raw,
    input wire logic [NUM_CH-1:0] thermal_raw,
    // Channel drive and status
    output logic [NUM_CH-1:0] hs_switch_on_r,
    output logic [NUM_CH-1:0] gate_drive_on_r,
    output fmop_pkg::fmop_summary_type summary_r,
    output logic fault_n_r
);

    localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

    if (NUM_CH != 4) begin : g_bad_num_ch
        $error("fmop_top serves exactly four channels");
    end
    if (DEBOUNCE_CYCLES < 1) begin : g_bad_debounce
        $error("fmop_top debounce count must be at least one");
    end

    logic [7:0] fault_pin_mask_r;
    logic [3:0] ch_input_mode_r;
    logic [7:0] open_wire_enable_r;
    logic [4:0] supply_short_detect_enable_r;
    logic [3:0] over_supply_channel_flag_r;
    logic [3:0] open_wire_channel_flag_r;
    logic [3:0] current_limit_channel_flag_r;
    logic [3:0] thermal_channel_flag_r;
    logic [3:0] debounced;
    logic [3:0] over_supply_clear;
    logic [3:0] gate_drive_enable;
    logic [3:0] open_wire_detect_enable;
    logic [3:0] protect_kill;
    logic over_supply_protect_enable;
    logic [7:0] reg_rdata_nxt;
    logic fault_nxt;

    assign gate_drive_enable = open_wire_enable_r[3:0];
    assign open_wire_detect_enable = open_wire_enable_r[7:4];
    assign over_supply_protect_enable = supply_short_detect_enable_r[fmop_pkg::PROTECT_ENABLE_BIT];

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fault_pin_mask_r <= fmop_pkg::FAULT_PIN_MASK_RESET;
            ch_input_mode_r <= fmop_pkg::CH_MODE_RESET;
            open_wire_enable_r <= fmop_pkg::OPEN_WIRE_ENABLE_RESET;
            supply_short_detect_enable_r <= fmop_pkg::SUPPLY_SHORT_DETECT_RESET;
        end else if (reg_req.wr) begin
            if (reg_req.addr == fmop_pkg::FAULT_PIN_MASK_ADDR) begin
                fault_pin_mask_r <= reg_req.wdata;
            end else if (reg_req.addr == fmop_pkg::CH_MODE_ADDR) begin
                ch_input_mode_r <= reg_req.wdata[3:0];
            end else if (reg_req.addr == fmop_pkg::OPEN_WIRE_ENABLE_ADDR) begin
                open_wire_enable_r <= reg_req.wdata;
            end else if (reg_req.addr == fmop_pkg::SUPPLY_SHORT_DETECT_ENABLE_ADDR) begin
                supply_short_detect_enable_r <= reg_req.wdata[4:0];
            end
        end
    end

    // Write one to an over-supply bit of the open-wire flag register clears it
    assign over_supply_clear = (reg_req.wr &&
        reg_req.addr == fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR) ? reg_req.wdata[7:4] : 4'h0;

    // ------------------------------------------------------------
    // Over-supply debounce and latch
    // ------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [CW-1:0] deb_cnt_r;

        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                deb_cnt_r <= '0;
            end else if (!over_supply_raw[i] || !supply_short_detect_enable_r[i]) begin
                deb_cnt_r <= '0;
            end else if (deb_cnt_r != CW'(DEBOUNCE_CYCLES)) begin
                deb_cnt_r <= deb_cnt_r + CW'(1);
            end
        end

        assign debounced[i] = (deb_cnt_r == CW'(DEBOUNCE_CYCLES));

        // Set wins over a clear in the same cycle
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                over_supply_channel_flag_r[i] <= 1'b0;
            end else if (debounced[i]) begin
                over_supply_channel_flag_r[i] <= 1'b1;
            end else if (over_supply_clear[i]) begin
                over_supply_channel_flag_r[i] <= 1'b0;
            end
        end

        assign protect_kill[i] = over_supply_channel_flag_r[i] && over_supply_protect_enable
            && gate_drive_enable[i] && !ch_input_mode_r[i];
    end

    // ------------------------------------------------------------
    // Live fault flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            open_wire_channel_flag_r <= 4'h0;
            current_limit_channel_flag_r <= 4'h0;
            thermal_channel_flag_r <= 4'h0;
        end else begin
            open_wire_channel_flag_r <= open_wire_raw & open_wire_detect_enable;
            current_limit_channel_flag_r <= current_limit_raw;
            thermal_channel_flag_r <= thermal_raw;
        end
    end

    // ------------------------------------------------------------
    // Channel drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hs_switch_on_r <= 4'h0;
            gate_drive_on_r <= 4'h0;
        end else begin
            hs_switch_on_r <= channel_line & {4{output_enable_in & output_sync_input}}
                & ~ch_input_mode_r & ~protect_kill;
            gate_drive_on_r <= gate_drive_enable & ~ch_input_mode_r & ~protect_kill;
        end
    end

    // ------------------------------------------------------------
    // Fault pin and serial summary
    // ------------------------------------------------------------
    always_comb begin
        fault_nxt = 1'b0;
        if (!fault_pin_mask_r[fmop_pkg::OVER_SUPPLY_MASK_BIT]) begin
            fault_nxt = fault_nxt | (|over_supply_channel_flag_r);
        end
        if (!fault_pin_mask_r[fmop_pkg::OPEN_WIRE_OFF_MASK_BIT]) begin
            fault_nxt = fault_nxt | (|open_wire_channel_flag_r);
        end
        if (!fault_pin_mask_r[fmop_pkg::CURRENT_LIMIT_MASK_BIT]) begin
            fault_nxt = fault_nxt | (|current_limit_channel_flag_r);
        end
        if (!fault_pin_mask_r[fmop_pkg::THERMAL_OVERLOAD_MASK_BIT]) begin
            fault_nxt = fault_nxt | (|thermal_channel_flag_r);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fault_n_r <= 1'b1;
            summary_r <= '0;
        end else begin
            fault_n_r <= !fault_nxt;
            summary_r.over_supply_summary_bit <= |over_supply_channel_flag_r;
            summary_r.open_wire_summary_bit <= |open_wire_channel_flag_r;
            summary_r.overcurrent_summary_bit <= |current_limit_channel_flag_r;
            summary_r.thermal_summary_bit <= |thermal_channel_flag_r;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb begin
        if (reg_req.addr == fmop_pkg::FAULT_PIN_MASK_ADDR) begin
            reg_rdata_nxt = fault_pin_mask_r;
        end else if (reg_req.addr == fmop_pkg::CH_MODE_ADDR) begin
            reg_rdata_nxt = {4'h0, ch_input_mode_r};
        end else if (reg_req.addr == fmop_pkg::OPEN_WIRE_ENABLE_ADDR) begin
            reg_rdata_nxt = open_wire_enable_r;
        end else if (reg_req.addr == fmop_pkg::SUPPLY_SHORT_DETECT_ENABLE_ADDR) begin
            reg_rdata_nxt = {3'h0, supply_short_detect_enable_r};
        end else if (reg_req.addr == fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR) begin
            reg_rdata_nxt = {over_supply_channel_flag_r, open_wire_channel_flag_r};
        end else if (reg_req.addr == fmop_pkg::OVERLOAD_CHANNEL_FLAGS_ADDR) begin
            reg_rdata_nxt = {current_limit_channel_flag_r, thermal_channel_flag_r};
        end else begin
            reg_rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_ovs_mask_blocks;
        fault_pin_mask_r[3] && fault_pin_mask_r[2] && fault_pin_mask_r[1]
            && fault_pin_mask_r[0] |=> fault_n_r;
    endproperty
    a_ovs_mask_blocks: assert property (p_ovs_mask_blocks) else $error("masked fault drove pin");

    property p_ovs_unmasked;
        !fault_pin_mask_r[3] && (|over_supply_channel_flag_r) |=> !fault_n_r;
    endproperty
    a_ovs_unmasked: assert property (p_ovs_unmasked) else $error("over-supply missed pin");

    property p_ow_unmasked;
        !fault_pin_mask_r[2] && (|open_wire_channel_flag_r) |=> !fault_n_r;
    endproperty
    a_ow_unmasked: assert property (p_ow_unmasked) else $error("open wire missed pin");

    property p_ow_flag;
        open_wire_raw[1] && open_wire_detect_enable[1] |=> open_wire_channel_flag_r[1]
            ##1 summary_r.open_wire_summary_bit;
    endproperty
    a_ow_flag: assert property (p_ow_flag) else $error("open wire flag late");

    property p_cl_unmasked;
        !fault_pin_mask_r[1] && (|current_limit_channel_flag_r) |=> !fault_n_r;
    endproperty
    a_cl_unmasked: assert property (p_cl_unmasked) else $error("current limit missed pin");

    property p_cl_always;
        current_limit_raw[1] |=> current_limit_channel_flag_r[1]
            ##1 summary_r.overcurrent_summary_bit;
    endproperty
    a_cl_always: assert property (p_cl_always) else $error("current limit not flagged");

    property p_th_unmasked;
        !fault_pin_mask_r[0] && (|thermal_channel_flag_r) |=> !fault_n_r;
    endproperty
    a_th_unmasked: assert property (p_th_unmasked) else $error("thermal missed pin");

    property p_th_always;
        thermal_raw[1] |=> thermal_channel_flag_r[1] ##1 summary_r.thermal_summary_bit;
    endproperty
    a_th_always: assert property (p_th_always) else $error("thermal not flagged");

    property p_hs_on;
        channel_line[0] && output_enable_in && output_sync_input && !ch_input_mode_r[0]
            && !protect_kill[0] |=> hs_switch_on_r[0];
    endproperty
    a_hs_on: assert property (p_hs_on) else $error("switch failed to turn on");

    property p_debounce;
        $rose(over_supply_channel_flag_r[0]) |-> $past(debounced[0]);
    endproperty
    a_debounce: assert property (p_debounce) else $error("flag set before debounce");

    property p_kill;
        protect_kill[0] |=> !hs_switch_on_r[0] && !gate_drive_on_r[0];
    endproperty
    a_kill: assert property (p_kill) else $error("protection did not switch off");

    property p_latched;
        over_supply_channel_flag_r[1] && !over_supply_clear[1] |=> over_supply_channel_flag_r[1];
    endproperty
    a_latched: assert property (p_latched) else $error("over-supply latch dropped");

    property p_input_gate_off;
        ch_input_mode_r[2] |=> !gate_drive_on_r[2] && !hs_switch_on_r[2];
    endproperty
    a_input_gate_off: assert property (p_input_gate_off) else $error("gate on in input mode");

    property p_gate_on;
        gate_drive_enable[1] && !ch_input_mode_r[1] && !protect_kill[1] |=> gate_drive_on_r[1];
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("gate enable ignored");

    property p_gate_off;
        !gate_drive_enable[0] |-> !protect_kill[0] ##1 !gate_drive_on_r[0];
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate on while disabled");

    property p_release;
        (fault_pin_mask_r[3] || over_supply_channel_flag_r == 4'h0)
            && (fault_pin_mask_r[2] || open_wire_channel_flag_r == 4'h0)
            && (fault_pin_mask_r[1] || current_limit_channel_flag_r == 4'h0)
            && (fault_pin_mask_r[0] || thermal_channel_flag_r == 4'h0) |=> fault_n_r;
    endproperty
    a_release: assert property (p_release) else $error("fault pin stuck");

    c_ovs_latch: cover property (over_supply_channel_flag_r[0] && protect_kill[0]);
    c_fault_pin: cover property ($fell(fault_n_r));
    c_clear: cover property (over_supply_channel_flag_r[0] ##1 !over_supply_channel_flag_r[0]);
    c_drive: cover property ($rose(hs_switch_on_r[1]));

endmodule

// File: bench/fmop_pin_host_model.sv
// Host-side pin driver for the data, enable and sync inputs
`timescale 1ns/10ps
module fmop_pin_host_model (
    // Clock
    input wire logic clk_sys,
    // Requests from the test sequence
    input wire logic serial_mode,
    input wire logic [3:0] want_on,
    input wire logic want_en,
    input wire logic want_sync,
    // Device pins
    output logic [3:0] channel_line,
    output logic output_enable_in,
    output logic output_sync_input
);
    // Data pins stay low under serial control, so nothing switches on at power-up
    initial begin
        channel_line = 4'h0;
        output_enable_in = 1'b0;
        output_sync_input = 1'b0;
        forever begin
            @(negedge clk_sys);
            channel_line <= serial_mode ? 4'h0 : want_on;
            output_enable_in <= want_en;
            output_sync_input <= want_sync;
        end
    end
endmodule

// File: bench/testbench.sv
// Self-checking testbench of the fault mask and over-supply protection block
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    fmop_pkg::fmop_reg_req_type reg_req = '0;
    logic [7:0] reg_rdata_r;
    logic [3:0] channel_line;
    logic output_enable_in;
    logic output_sync_input;
    logic [3:0] raw_src [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
    logic [3:0] hs_switch_on_r;
    logic [3:0] gate_drive_on_r;
    fmop_pkg::fmop_summary_type summary_r;
    logic fault_n_r;
    logic serial_mode = 1'b1;
    logic [3:0] want_on = 4'h0;
    logic want_en = 1'b0;
    logic want_sync = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    fmop_top #(.NUM_CH(4), .DEBOUNCE_CYCLES(4)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
        .channel_line(channel_line), .output_enable_in(output_enable_in),
        .output_sync_input(output_sync_input), .over_supply_raw(raw_src[3]),
        .open_wire_raw(raw_src[2]), .current_limit_raw(raw_src[1]),
        .thermal_raw(raw_src[0]), .hs_switch_on_r(hs_switch_on_r),
        .gate_drive_on_r(gate_drive_on_r), .summary_r(summary_r), .fault_n_r(fault_n_r)
    );

    fmop_pin_host_model u_host (
        .clk_sys(clk_sys), .serial_mode(serial_mode), .want_on(want_on),
        .want_en(want_en), .want_sync(want_sync), .channel_line(channel_line),
        .output_enable_in(output_enable_in), .output_sync_input(output_sync_input)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        reg_req <= '{wr: 1'b1, addr: addr, wdata: data};
        @(negedge clk_sys);
        reg_req.wr <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        reg_req.addr <= addr;
        @(negedge clk_sys);
        check("reg_rdata_r", exp, reg_rdata_r);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        wait_cyc(20);
        rst_n <= 1'b1;
        wait_cyc(1);
        check("fault_n_r", 8'h01, {7'h00, fault_n_r});
        reg_read(fmop_pkg::FAULT_PIN_MASK_ADDR, fmop_pkg::FAULT_PIN_MASK_RESET);
        reg_read(fmop_pkg::CH_MODE_ADDR, 8'h00);
        reg_read(8'h07, 8'h00);
        reg_write(fmop_pkg::OVERLOAD_CHANNEL_FLAGS_ADDR, 8'hff);
        reg_read(fmop_pkg::OVERLOAD_CHANNEL_FLAGS_ADDR, 8'h00);
        // Pin control in the default mode
        serial_mode = 1'b0;
        want_on = 4'hf;
        want_en = 1'b1;
        wait_cyc(3);
        check("hs_switch_on_r", 8'h00, {4'h0, hs_switch_on_r});
        want_sync = 1'b1;
        wait_cyc(3);
        check("hs_switch_on_r", 8'h0f, {4'h0, hs_switch_on_r});
        // Thermal, current limit and open wire through the mask, one at a time
        for (int s = 0; s < 3; s++) begin
            raw_src[s] = 4'h2;
            wait_cyc(3);
            if (s == 2) begin
                reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h00);
                reg_write(fmop_pkg::OPEN_WIRE_ENABLE_ADDR, 8'h20);
                wait_cyc(3);
            end
            reg_write(fmop_pkg::FAULT_PIN_MASK_ADDR, 8'hf0 | (8'h0f & ~(8'h01 << s)));
            wait_cyc(3);
            check("fault_n_r", 8'h00, {7'h00, fault_n_r});
            check("summary_r", 8'h01 << s, {4'h0, summary_r});
            reg_write(fmop_pkg::FAULT_PIN_MASK_ADDR, 8'hff);
            wait_cyc(3);
            check("fault_n_r", 8'h01, {7'h00, fault_n_r});
            check("summary_r", 8'h01 << s, {4'h0, summary_r});
            if (s == 2) begin
                reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h02);
            end else begin
                reg_read(fmop_pkg::OVERLOAD_CHANNEL_FLAGS_ADDR, (s == 0) ? 8'h02 : 8'h20);
            end
            raw_src[s] = 4'h0;
            wait_cyc(3);
            check("summary_r", 8'h00, {4'h0, summary_r});
        end
        // Over-supply with protection and gate drive enabled
        reg_write(fmop_pkg::SUPPLY_SHORT_DETECT_ENABLE_ADDR, 8'h1f);
        reg_write(fmop_pkg::OPEN_WIRE_ENABLE_ADDR, 8'h0f);
        reg_write(fmop_pkg::FAULT_PIN_MASK_ADDR, 8'hf7);
        wait_cyc(3);
        check("gate_drive_on_r", 8'h0f, {4'h0, gate_drive_on_r});
        raw_src[3] = 4'h1;
        wait_cyc(3);
        raw_src[3] = 4'h0;
        wait_cyc(3);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h00);
        check("fault_n_r", 8'h01, {7'h00, fault_n_r});
        raw_src[3] = 4'h1;
        wait_cyc(9);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h10);
        check("fault_n_r", 8'h00, {7'h00, fault_n_r});
        check("summary_r", 8'h08, {4'h0, summary_r});
        check("hs_switch_on_r", 8'h0e, {4'h0, hs_switch_on_r});
        check("gate_drive_on_r", 8'h0e, {4'h0, gate_drive_on_r});
        raw_src[3] = 4'h0;
        wait_cyc(4);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h10);
        check("hs_switch_on_r", 8'h0e, {4'h0, hs_switch_on_r});
        reg_write(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h10);
        wait_cyc(3);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h00);
        check("hs_switch_on_r", 8'h0f, {4'h0, hs_switch_on_r});
        check("fault_n_r", 8'h01, {7'h00, fault_n_r});
        // Gate drive disabled: flag only, outputs untouched
        reg_write(fmop_pkg::OPEN_WIRE_ENABLE_ADDR, 8'h00);
        raw_src[3] = 4'h2;
        wait_cyc(9);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h20);
        check("gate_drive_on_r", 8'h00, {4'h0, gate_drive_on_r});
        check("hs_switch_on_r", 8'h0f, {4'h0, hs_switch_on_r});
        raw_src[3] = 4'h0;
        wait_cyc(1);
        reg_write(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h20);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h00);
        // Input mode holds the gate off
        reg_write(fmop_pkg::OPEN_WIRE_ENABLE_ADDR, 8'h0f);
        reg_write(fmop_pkg::CH_MODE_ADDR, 8'h05);
        wait_cyc(3);
        check("gate_drive_on_r", 8'h0a, {4'h0, gate_drive_on_r});
        check("hs_switch_on_r", 8'h0a, {4'h0, hs_switch_on_r});
        // Detection off, then protection off: no flag, then flag without switch-off
        reg_write(fmop_pkg::SUPPLY_SHORT_DETECT_ENABLE_ADDR, 8'h17);
        raw_src[3] = 4'h8;
        wait_cyc(9);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h00);
        check("hs_switch_on_r", 8'h0a, {4'h0, hs_switch_on_r});
        reg_write(fmop_pkg::SUPPLY_SHORT_DETECT_ENABLE_ADDR, 8'h0f);
        wait_cyc(9);
        reg_read(fmop_pkg::OPEN_WIRE_CHANNEL_FLAGS_ADDR, 8'h80);
        check("fault_n_r", 8'h00, {7'h00, fault_n_r});
        check("gate_drive_on_r", 8'h0a, {4'h0, gate_drive_on_r});
        check("hs_switch_on_r", 8'h0a, {4'h0, hs_switch_on_r});
        finish_test();
    end
endmodule
